/* File: design/event_irq.sv */
// sticky event flags with write-one-to-clear and a mask
// assumes set pulses and clear strobes on the same clock
`timescale 1ns/1ps
module event_irq
#(
    parameter int N = 4
)
(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [N-1:0] ev_set,
    input  wire logic         clr_we,
    input  wire logic [N-1:0] clr_bits,
    input  wire logic         mask_we,
    input  wire logic [N-1:0] mask_wd,
    output logic      [N-1:0] stat_q,
    output logic      [N-1:0] mask_q,
    output logic              irq_any
);
    initial
    begin
        if (N < 1 || N > 8)
            $error("event_irq: N must be 1 to 8");
    end

    genvar i;
    generate
        for (i = 0; i < N; i++)
        begin : g_bit
            // set beats a clear in the same cycle
            wire d = ev_set[i] | (stat_q[i] & ~(clr_we & clr_bits[i]));
            always_ff @(posedge clk)
            begin
                if (rst)
                    stat_q[i] <= 1'b0;
                else
                    stat_q[i] <= d;
            end
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (rst)
            mask_q <= '0;
        else if (mask_we)
            mask_q <= mask_wd;
    end

    assign irq_any = |(stat_q & mask_q);
endmodule : event_irq

/* File: design/flash_status_and_protect_guard.sv */
// command status, protection guard and command queue of a flash
// controller; the erase/program engine sits outside and reports back
// through CMD_DONE and the verify strobes
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`include "flash_guard_params.svh"
// What this block does
// [R1] protection may only grow or stay equal, never be lifted
// [R2] writes that would lift protection are dropped, register unchanged
// [R3] protection register reads back the scenario in force
// [R4] normal mode: buffer-empty, violation, error writable; others fixed
// [R5] special mode: fail read/write, done read-only; software clears fail
// [R6] buffer-empty reads one when buffers free; write one clears it
// [R7] zero to buffer-empty mid-sequence aborts and flags access error
// [R8] interrupt when buffer-empty and its enable are both set
// [R9] finished flag low while buffer full, high once all done
// [R10] finished flag stays low while a queued command is taken
// [R11] interrupt when finished flag and its enable are both set
// [R12] violation on protected program or erase; write one clears; blocks
// [R13] access error on sequence fault, illegal code, stop while busy
// [R14] access error cleared only by writing one; blocks launch
// [R15] blank set by passing verify, cleared by a valid new launch
// [R16] special mode fail set by failing verify; write one clears; blocks
// [R17] special mode done reads zero while an operation runs
// [R18] only the four known command codes are legal
// [R19] several clear bits in one status write clear independently
module flash_status_and_protect_guard
(
    input  wire logic                   CORE_CLK,
    input  wire logic                   RST,
    input  wire logic                   PSEL,
    input  wire logic                   PENABLE,
    input  wire logic                   PWRITE,
    input  wire flash_guard_pkg::addr_t PADDR,
    input  wire flash_guard_pkg::word_t PWDATA,
    output flash_guard_pkg::word_t      PRDATA,
    output logic                        PREADY,
    output logic                        PSLVERR,
    input  wire logic                   SPECIAL_MODE,
    input  wire logic                   FLASH_WORD_WR,
    input  wire logic                   FLASH_PROT_HIT,
    input  wire logic                   STOP_REQ,
    input  wire logic                   CMD_DONE,
    input  wire logic                   VERIFY_DONE,
    input  wire logic                   VERIFY_BLANK,
    output logic                        CMD_START,
    output flash_guard_pkg::byte_t      CMD_CODE,
    output logic                        CMD_ACTIVE,
    output flash_guard_pkg::byte_t      PROT_SETTING,
    output logic                        IRQ
);
    import flash_guard_pkg::*;

    function automatic logic is_legal(input byte_t c);
        is_legal = (c == `CMD_VERIFY) || (c == `CMD_PROG) ||
                   (c == `CMD_SECTOR) || (c == `CMD_MASS);
    endfunction : is_legal

    seq_state_t seq_q;
    seq_state_t seq_d;
    byte_t      cfg_q;
    byte_t      buf_cmd_q;
    byte_t      act_cmd_q;
    logic       buf_full_q;
    logic       active_q;
    logic       start_q;
    logic       protect_violation_flag_q;
    logic       access_error_flag_q;
    logic       blank_q;
    logic       fail_q;
    word_t      prdata_q;
    byte_t      prot_q;
    logic       prot_ok;
    logic [`EV_N-1:0] ev_stat;
    logic [`EV_N-1:0] ev_mask;
    logic             ev_irq;

    // bus decode; zero wait states, read data caught in setup
    wire [9:0] idx      = PADDR[11:2];
    wire       aligned  = PADDR[1:0] == 2'b00;
    wire       hit_cfg  = aligned && idx == `IDX_CONFIG;
    wire       hit_prot = aligned && idx == `IDX_PROTECT;
    wire       hit_st   = aligned && idx == `IDX_STATUS;
    wire       hit_cmd  = aligned && idx == `IDX_COMMAND;
    wire       hit_evs  = aligned && idx == `IDX_EV_STAT;
    wire       hit_evm  = aligned && idx == `IDX_EV_MASK;
    wire       hit_any  = hit_cfg | hit_prot | hit_st | hit_cmd |
                          hit_evs | hit_evm;
    wire       setup    = PSEL && !PENABLE;
    wire       access   = PSEL && PENABLE;
    wire       wr       = access && PWRITE && hit_any;
    wire byte_t wd      = PWDATA[7:0];
    wire       st_wr    = wr && hit_st;
    wire       cmd_wr   = wr && hit_cmd;

    // queue: one buffered command behind one active command
    wire buffer_empty_flag = !buf_full_q; // [R6]
    wire all_commands_finished_flag  = !active_q && !buf_full_q; // [R9] [R10]
    wire start = buf_full_q && (!active_q || CMD_DONE);
    wire special_fail = SPECIAL_MODE && fail_q;

    // sequence decoding
    wire in_seq    = seq_q != SEQ_IDLE;
    wire wr1_cbe   = st_wr && wd[`ST_CBE];
    wire launch_rq = wr1_cbe && buffer_empty_flag && seq_q == SEQ_CMD;
    wire launch    = launch_rq && !access_error_flag_q && !protect_violation_flag_q && // [R12] [R14]
                     !special_fail; // [R16]
    wire abort0    = st_wr && !wd[`ST_CBE] && in_seq; // [R7]
    wire cmd_bad   = cmd_wr && (seq_q != SEQ_ADDR || // [R13]
                     !is_legal(wd)); // [R18]
    wire word_bad  = FLASH_WORD_WR && in_seq; // [R13]
    wire wr1_early = wr1_cbe && buffer_empty_flag && seq_q == SEQ_ADDR; // [R13]
    wire stop_err  = STOP_REQ && !all_commands_finished_flag; // [R13]
    wire acc_set   = abort0 | cmd_bad | word_bad | wr1_early | stop_err;
    wire pvl_set   = FLASH_PROT_HIT; // [R12]
    wire ev_ccf    = active_q && CMD_DONE && !buf_full_q;

    always_comb
    begin
        seq_d = seq_q;
        if (acc_set || pvl_set || launch_rq)
            seq_d = SEQ_IDLE;
        else if (FLASH_WORD_WR && seq_q == SEQ_IDLE)
            seq_d = SEQ_ADDR;
        else if (cmd_wr)
            seq_d = SEQ_CMD;
    end

    // flags: a hardware set wins over a software clear
    wire clr_pvl = st_wr && wd[`ST_PVL]; // [R19]
    wire clr_acc = st_wr && wd[`ST_ACC]; // [R19]
    wire clr_fail = st_wr && wd[`ST_FAIL] && SPECIAL_MODE; // [R5]
    wire protect_violation_flag_d = pvl_set | (protect_violation_flag_q & !clr_pvl); // [R12]
    wire access_error_flag_d = acc_set | (access_error_flag_q & !clr_acc); // [R14]
    wire blank_set = VERIFY_DONE && VERIFY_BLANK;
    wire blank_d = blank_set | (blank_q & !launch); // [R15]
    wire fail_set = VERIFY_DONE && !VERIFY_BLANK && SPECIAL_MODE;
    wire fail_d = fail_set | (fail_q & !clr_fail); // [R16]

    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            seq_q    <= SEQ_IDLE;
            protect_violation_flag_q  <= 1'b0;
            access_error_flag_q <= 1'b0;
            blank_q  <= 1'b0;
            fail_q   <= 1'b0;
        end
        else
        begin
            seq_q    <= seq_d;
            protect_violation_flag_q  <= protect_violation_flag_d;
            access_error_flag_q <= access_error_flag_d;
            blank_q  <= blank_d;
            fail_q   <= fail_d;
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
            buf_cmd_q <= 8'h00;
        else if (cmd_wr && !cmd_bad)
            buf_cmd_q <= wd;
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            buf_full_q <= 1'b0;
            active_q   <= 1'b0;
            start_q    <= 1'b0;
            act_cmd_q  <= 8'h00;
        end
        else
        begin
            buf_full_q <= launch | (buf_full_q & !start); // [R6]
            active_q   <= start | (active_q & !CMD_DONE); // [R10]
            start_q    <= start;
            if (start)
                act_cmd_q <= buf_cmd_q;
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
            cfg_q <= `CFG_RESET;
        else if (wr && hit_cfg)
            cfg_q <= wd;
    end

    prot_guard prot_guard_i
    (
        .clk     (CORE_CLK),
        .rst     (RST),
        .wr_en   (wr && hit_prot), // [R2]
        .wr_data (wd),
        .prot_q  (prot_q),
        .wr_ok   (prot_ok)
    );

    wire [`EV_N-1:0] ev_set;
    assign ev_set[`EV_CBE] = start;
    assign ev_set[`EV_CCF] = ev_ccf;
    assign ev_set[`EV_PVL] = pvl_set;
    assign ev_set[`EV_ACC] = acc_set;

    event_irq #(.N(`EV_N)) event_irq_i
    (
        .clk      (CORE_CLK),
        .rst      (RST),
        .ev_set   (ev_set),
        .clr_we   (wr && hit_evs),
        .clr_bits (wd[`EV_N-1:0]),
        .mask_we  (wr && hit_evm),
        .mask_wd  (wd[`EV_N-1:0]),
        .stat_q   (ev_stat),
        .mask_q   (ev_mask),
        .irq_any  (ev_irq)
    );

    // status readback; fail and done hidden outside special mode
    wire byte_t status_rd; // [R4]
    assign status_rd[`ST_CBE]  = buffer_empty_flag;
    assign status_rd[`ST_CCF]  = all_commands_finished_flag;
    assign status_rd[`ST_PVL]  = protect_violation_flag_q;
    assign status_rd[`ST_ACC]  = access_error_flag_q;
    assign status_rd[`ST_RSVD] = 1'b0;
    assign status_rd[`ST_BLK]  = blank_q;
    assign status_rd[`ST_FAIL] = SPECIAL_MODE && fail_q; // [R5]
    assign status_rd[`ST_DONE] = SPECIAL_MODE && !active_q; // [R17]

    wire byte_t cmd_rd = in_seq ? (buf_cmd_q & `CMD_RD_MASK) : 8'h00;
    wire byte_t rd_byte =
        hit_cfg  ? cfg_q :
        hit_prot ? prot_q : // [R3]
        hit_st   ? status_rd :
        hit_cmd  ? cmd_rd :
        hit_evs  ? {4'h0, ev_stat} :
        hit_evm  ? {4'h0, ev_mask} : 8'h00;

    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
            prdata_q <= 32'h0000_0000;
        else if (setup)
            prdata_q <= {24'h00_0000, rd_byte};
    end

    wire irq_cbe = buffer_empty_flag && cfg_q[`CF_BUFFER_EMPTY_IRQ_ENABLE]; // [R8]
    wire irq_ccf = all_commands_finished_flag && cfg_q[`CF_FINISHED_IRQ_ENABLE]; // [R11]

    assign PRDATA       = prdata_q;
    assign PREADY       = 1'b1;
    assign PSLVERR      = access && !hit_any;
    assign CMD_START    = start_q;
    assign CMD_CODE     = act_cmd_q;
    assign CMD_ACTIVE   = active_q;
    assign PROT_SETTING = prot_q; // [R3]
    assign IRQ          = irq_cbe | irq_ccf | ev_irq;

    property p_cbe_irq;
        @(posedge CORE_CLK) disable iff (RST)
        (buffer_empty_flag && cfg_q[`CF_BUFFER_EMPTY_IRQ_ENABLE]) |-> IRQ;
    endproperty
    a_cbe_irq : assert property (p_cbe_irq) // [R8]
        else $error("buffer empty interrupt missing");

    property p_ccf_irq;
        @(posedge CORE_CLK) disable iff (RST)
        (status_rd[`ST_CCF] && cfg_q[`CF_FINISHED_IRQ_ENABLE]) |-> IRQ;
    endproperty
    a_ccf_irq : assert property (p_ccf_irq) // [R11]
        else $error("finished interrupt missing");

    property p_ccf_low;
        @(posedge CORE_CLK) disable iff (RST)
        !status_rd[`ST_CBE] |-> !status_rd[`ST_CCF];
    endproperty
    a_ccf_low : assert property (p_ccf_low) // [R9]
        else $error("finished flag high while buffer full");

    property p_queue_take;
        @(posedge CORE_CLK) disable iff (RST)
        (active_q && buf_full_q && CMD_DONE) |=>
            (!status_rd[`ST_CCF] && active_q);
    endproperty
    a_queue_take : assert property (p_queue_take) // [R10]
        else $error("finished flag rose with a queued command");

    property p_abort;
        @(posedge CORE_CLK) disable iff (RST)
        (st_wr && !wd[`ST_CBE] && seq_q != SEQ_IDLE) |=>
            (access_error_flag_q && seq_q == SEQ_IDLE);
    endproperty
    a_abort : assert property (p_abort) // [R7]
        else $error("zero to buffer empty did not abort");

    property p_block;
        @(posedge CORE_CLK) disable iff (RST)
        (access_error_flag_q || protect_violation_flag_q) |=> !buf_full_q || $past(buf_full_q);
    endproperty
    a_block : assert property (p_block) // [R14]
        else $error("command launched while an error flag was set");

    property p_protect_violation_flag;
        @(posedge CORE_CLK) disable iff (RST)
        FLASH_PROT_HIT |=> status_rd[`ST_PVL];
    endproperty
    a_protect_violation_flag : assert property (p_protect_violation_flag) // [R12]
        else $error("violation flag not set");

    property p_hidden;
        @(posedge CORE_CLK) disable iff (RST)
        !SPECIAL_MODE |-> (!status_rd[`ST_FAIL] && !status_rd[`ST_DONE] &&
                           !status_rd[`ST_RSVD]);
    endproperty
    a_hidden : assert property (p_hidden) // [R4]
        else $error("fail or done visible in normal mode");

    property p_done;
        @(posedge CORE_CLK) disable iff (RST)
        SPECIAL_MODE |-> (status_rd[`ST_DONE] == !CMD_ACTIVE);
    endproperty
    a_done : assert property (p_done) // [R17]
        else $error("done flag does not track activity");

    property p_illegal;
        @(posedge CORE_CLK) disable iff (RST)
        (cmd_wr && !is_legal(wd)) |=> access_error_flag_q;
    endproperty
    a_illegal : assert property (p_illegal) // [R18]
        else $error("illegal command not flagged");

    // buffered code must reach the engine with the start strobe
    property p_take_cmd;
        @(posedge CORE_CLK) disable iff (RST)
        start |=>
            (CMD_START && CMD_ACTIVE && CMD_CODE == $past(buf_cmd_q));
    endproperty
    a_take_cmd : assert property (p_take_cmd) // [R10]
        else $error("buffered command not handed to the engine");

    property p_prot_drop;
        @(posedge CORE_CLK) disable iff (RST)
        (wr && hit_prot && !prot_ok) |=>
            (PROT_SETTING == $past(PROT_SETTING));
    endproperty
    a_prot_drop : assert property (p_prot_drop) // [R2]
        else $error("lifting protection write was taken");
endmodule : flash_status_and_protect_guard

/* File: design/prot_guard.sv */
// protection setting register that only accepts added protection
// assumes writes arrive as one-cycle strobes on the core clock
`timescale 1ns/1ps
`include "flash_guard_params.svh"
module prot_guard
(
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  wr_en,
    input  wire flash_guard_pkg::byte_t wr_data,
    output flash_guard_pkg::byte_t     prot_q,
    output logic                       wr_ok
);
    import flash_guard_pkg::*;

    // size code to nested pieces, smallest piece always included
    function automatic logic [3:0] thermo(input logic [1:0] s);
        thermo = {s == 2'b11, s[1], |s, 1'b1};
    endfunction : thermo

    // protected pieces: {rest of array, 4 high pieces, 4 low pieces}
    function automatic cover_t coverage(input byte_t p);
        logic [3:0] hi;
        logic [3:0] lo;
        hi = thermo(p[4:3]);
        lo = thermo(p[1:0]);
        if (p[`PR_OPEN])
            coverage = {1'b0, p[`PR_HDIS] ? 4'h0 : hi,
                        p[`PR_LDIS] ? 4'h0 : lo};
        else
            coverage = {1'b1, p[`PR_HDIS] ? 4'hf : ~hi,
                        p[`PR_LDIS] ? 4'hf : ~lo};
    endfunction : coverage

    wire cover_t old_cov = coverage(prot_q);
    wire cover_t new_cov = coverage(wr_data);

    // any piece losing protection makes the whole write void
    assign wr_ok = (old_cov & ~new_cov) == 9'h000; // [R1]

    always_ff @(posedge clk)
    begin
        if (rst)
            prot_q <= `PROT_RESET;
        else if (wr_en && wr_ok)
            prot_q <= wr_data; // [R1] [R3]
    end

    property p_prot_mono;
        @(posedge clk) disable iff (rst)
        (prot_q != $past(prot_q)) |->
            ((coverage($past(prot_q)) & ~coverage(prot_q)) == 9'h000);
    endproperty
    a_prot_mono : assert property (p_prot_mono) // [R1]
        else $error("protection was lifted");

    property p_prot_hold;
        @(posedge clk) disable iff (rst)
        (wr_en && !wr_ok) |=> (prot_q == $past(prot_q));
    endproperty
    a_prot_hold : assert property (p_prot_hold) // [R2]
        else $error("rejected protection write changed the register");
endmodule : prot_guard

/* File: inc/flash_guard_params.svh */
// constants of the flash status and protection guard
// assumes 12-bit APB byte addresses, one register per word
`ifndef FLASH_GUARD_PARAMS_SVH
`define FLASH_GUARD_PARAMS_SVH
`define IDX_CONFIG   10'h003
`define IDX_PROTECT  10'h004
`define IDX_STATUS   10'h005
`define IDX_COMMAND  10'h006
`define IDX_EV_STAT  10'h010
`define IDX_EV_MASK  10'h011
`define ST_CBE       7
`define ST_CCF       6
`define ST_PVL       5
`define ST_ACC       4
`define ST_RSVD      3
`define ST_BLK       2
`define ST_FAIL      1
`define ST_DONE      0
`define CF_BUFFER_EMPTY_IRQ_ENABLE     7
`define CF_FINISHED_IRQ_ENABLE      6
`define CMD_VERIFY   8'h05
`define CMD_PROG     8'h20
`define CMD_SECTOR   8'h40
`define CMD_MASS     8'h41
`define CMD_RD_MASK  8'h65
`define PR_OPEN      7
`define PR_HDIS      5
`define PR_LDIS      2
`define PROT_RESET   8'hff
`define CFG_RESET    8'h00
`define EV_CBE       0
`define EV_CCF       1
`define EV_PVL       2
`define EV_ACC       3
`define EV_N         4
`endif

/* File: inc/flash_guard_pkg.sv */
// types shared by the flash status and protection guard
// assumes nothing beyond the constants header
package flash_guard_pkg;
    typedef logic [7:0]  byte_t;
    typedef logic [31:0] word_t;
    typedef logic [11:0] addr_t;
    typedef logic [8:0]  cover_t;
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_ADDR, SEQ_CMD} seq_state_t;
endpackage : flash_guard_pkg

/* File: tb/flash_status_and_protect_guard_tb_top.sv */
// self-checking bench for the flash status and protection guard
// assumes zero-wait APB slave and the engine strobes driven here
`timescale 1ns/1ps
`include "flash_guard_params.svh"
module flash_status_and_protect_guard_tb_top;
    import flash_guard_pkg::*;
    logic        clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    addr_t       paddr;
    word_t       pwdata;
    word_t       prdata;
    logic        pready;
    logic        pslverr;
    logic        special;
    logic        vblank;
    logic [4:0]  pulses;
    logic        cmd_start;
    byte_t       cmd_code;
    logic        cmd_active;
    byte_t       prot;
    logic        irq;
    int          mismatches;
    int          comparisons;
    byte_t       q;
    logic        err;

    flash_status_and_protect_guard flash_status_and_protect_guard_i
    (
        .CORE_CLK       (clk),
        .RST            (rst),
        .PSEL           (psel),
        .PENABLE        (penable),
        .PWRITE         (pwrite),
        .PADDR          (paddr),
        .PWDATA         (pwdata),
        .PRDATA         (prdata),
        .PREADY         (pready),
        .PSLVERR        (pslverr),
        .SPECIAL_MODE   (special),
        .FLASH_WORD_WR  (pulses[0]),
        .FLASH_PROT_HIT (pulses[1]),
        .STOP_REQ       (pulses[2]),
        .CMD_DONE       (pulses[3]),
        .VERIFY_DONE    (pulses[4]),
        .VERIFY_BLANK   (vblank),
        .CMD_START      (cmd_start),
        .CMD_CODE       (cmd_code),
        .CMD_ACTIVE     (cmd_active),
        .PROT_SETTING   (prot),
        .IRQ            (irq)
    );

    function automatic addr_t ba(input logic [9:0] idx);
        return {idx, 2'b00};
    endfunction : ba

    task automatic check(input byte_t seen, input byte_t exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one transfer; caller is just past a rising edge
    task automatic apb(input logic is_wr, input addr_t a, input byte_t d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= is_wr;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // no wait-state count assumed; only the watchdog ends a stall
        while (pready !== 1'b1)
            @(posedge clk);
        q   = prdata[7:0];
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // idle edge so the next setup never lands in this time step
        @(posedge clk);
    endtask : apb

    task automatic wr(input logic [9:0] idx, input byte_t d);
        apb(1'b1, ba(idx), d);
    endtask : wr

    task automatic rd(input logic [9:0] idx, input byte_t exp);
        apb(1'b0, ba(idx), 8'h00);
        check(q, exp);
    endtask : rd

    task automatic pulse(input int which);
        pulses <= 5'h01 << which;
        @(posedge clk);
        pulses <= 5'h00;
        @(posedge clk);
    endtask : pulse

    task automatic launch(input byte_t code);
        pulse(0);
        wr(`IDX_COMMAND, code);
        wr(`IDX_STATUS, 8'h80);
    endtask : launch

    task automatic wait_active(input byte_t code);
        int n;
        n = 0;
        while (cmd_active !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge clk);
        end
        check({7'h0, cmd_active}, 8'h01);
        check(cmd_code, code);
        // engine start strobe rises with active and lasts one cycle
        check({7'h0, cmd_start}, 8'h01);
        @(posedge clk);
        check({7'h0, cmd_start}, 8'h00);
    endtask : wait_active

    task automatic finish_test;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // whole run is a few hundred cycles
    initial
    begin
        #(40 * 20000);
        mismatches++;
        finish_test();
    end

    initial
    begin
        mismatches = 0;
        comparisons = 0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        special = 1'b0;
        vblank = 1'b0;
        pulses = 5'h00;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(`IDX_STATUS, 8'hc0);
        wr(`IDX_STATUS, 8'h4f);
        rd(`IDX_STATUS, 8'hc0);
        rd(`IDX_PROTECT, 8'hff);
        wr(`IDX_PROTECT, 8'hdf);
        rd(`IDX_PROTECT, 8'hdf);
        wr(`IDX_PROTECT, 8'hff);
        rd(`IDX_PROTECT, 8'hdf);
        check(prot, 8'hdf);
        apb(1'b0, 12'h3fc, 8'h00);
        check({7'h0, err}, 8'h01);
        check(q, 8'h00);
        // illegal code, then launch refused while error stands
        pulse(0);
        wr(`IDX_COMMAND, 8'h11);
        rd(`IDX_STATUS, 8'hd0);
        wr(`IDX_STATUS, 8'h00);
        rd(`IDX_STATUS, 8'hd0);
        launch(`CMD_PROG);
        check({7'h0, cmd_active}, 8'h00);
        wr(`IDX_STATUS, 8'h10);
        rd(`IDX_STATUS, 8'hc0);
        // abort mid-sequence plus violation, cleared in one write
        pulse(0);
        wr(`IDX_STATUS, 8'h00);
        pulse(1);
        rd(`IDX_STATUS, 8'hf0);
        wr(`IDX_STATUS, 8'h00);
        rd(`IDX_STATUS, 8'hf0);
        wr(`IDX_STATUS, 8'h30);
        rd(`IDX_STATUS, 8'hc0);
        pulse(1);
        launch(`CMD_PROG);
        check({7'h0, cmd_active}, 8'h00);
        wr(`IDX_STATUS, 8'h20);
        // verify passes, next launch clears blank
        launch(`CMD_VERIFY);
        wait_active(`CMD_VERIFY);
        rd(`IDX_STATUS, 8'h80);
        vblank <= 1'b1;
        pulse(4);
        pulse(3);
        rd(`IDX_STATUS, 8'hc4);
        // command readback mid-sequence, then launch by hand
        pulse(0);
        wr(`IDX_COMMAND, `CMD_MASS);
        rd(`IDX_COMMAND, 8'h41);
        wr(`IDX_STATUS, 8'h80);
        wait_active(`CMD_MASS);
        rd(`IDX_STATUS, 8'h80);
        pulse(3);
        rd(`IDX_STATUS, 8'hc0);
        // queued command keeps finished low
        launch(`CMD_PROG);
        wait_active(`CMD_PROG);
        launch(`CMD_SECTOR);
        rd(`IDX_STATUS, 8'h00);
        pulse(3);
        wait_active(`CMD_SECTOR);
        rd(`IDX_STATUS, 8'h80);
        pulse(2);
        rd(`IDX_STATUS, 8'h90);
        pulse(3);
        wr(`IDX_STATUS, 8'h10);
        rd(`IDX_STATUS, 8'hc0);
        // interrupts from flags and from masked events
        wr(`IDX_EV_STAT, 8'h0f);
        wr(`IDX_EV_MASK, 8'h00);
        wr(`IDX_CONFIG, 8'h80);
        check({7'h0, irq}, 8'h01);
        wr(`IDX_CONFIG, 8'h40);
        check({7'h0, irq}, 8'h01);
        wr(`IDX_CONFIG, 8'h00);
        check({7'h0, irq}, 8'h00);
        wr(`IDX_EV_MASK, 8'h04);
        pulse(1);
        rd(`IDX_EV_STAT, 8'h04);
        check({7'h0, irq}, 8'h01);
        wr(`IDX_STATUS, 8'h20);
        wr(`IDX_EV_STAT, 8'h04);
        check({7'h0, irq}, 8'h00);
        // special mode: done and fail
        special <= 1'b1;
        @(posedge clk);
        rd(`IDX_STATUS, 8'hc1);
        launch(`CMD_VERIFY);
        wait_active(`CMD_VERIFY);
        rd(`IDX_STATUS, 8'h80);
        vblank <= 1'b0;
        pulse(4);
        pulse(3);
        rd(`IDX_STATUS, 8'hc3);
        launch(`CMD_PROG);
        check({7'h0, cmd_active}, 8'h00);
        wr(`IDX_STATUS, 8'h00);
        rd(`IDX_STATUS, 8'hc3);
        wr(`IDX_STATUS, 8'h02);
        rd(`IDX_STATUS, 8'hc1);
        finish_test();
    end
endmodule : flash_status_and_protect_guard_tb_top
